// ===== hw/omsc_defines.vh
// omsc_defines.vh: offsets, field positions, reset values and oscillator codes
// for the operating mode and sleep control block; definitions only
`ifndef OMSC_DEFINES_VH
`define OMSC_DEFINES_VH

// register offsets (word index on the plain register port)
`define OMSC_ADDR_W 4
`define OMSC_SYSTEM_CONTROL_ZERO_ADDR 4'h0
`define OMSC_STATUS_ADDR 4'h1
`define OMSC_MODE_ADDR 4'h2
`define OMSC_IRQ_STAT_ADDR 4'h3
`define OMSC_IRQ_MASK_ADDR 4'h4
`define OMSC_WDT_ADDR 4'h5

// system_control_zero fields
`define OMSC_SYSTEM_CONTROL_ZERO_SPEED_BIT 0
`define OMSC_SYSTEM_CONTROL_ZERO_CRYSTAL_LOW_POWER_BIT_BIT 1
`define OMSC_SYSTEM_CONTROL_ZERO_RESET 8'h00

// status fields
`define OMSC_STAT_TO_BIT 0
`define OMSC_STAT_PDF_BIT 1

// interrupt event bits
`define OMSC_EV_SLEEP_BIT 0
`define OMSC_EV_WAKE_BIT 1
`define OMSC_EV_MODE_BIT 2
`define OMSC_EV_W 3

// oscillator configuration codes
`define OMSC_CFG_HXT 2'h0
`define OMSC_CFG_ERC 2'h1
`define OMSC_CFG_INTERNAL_HIGH_SPEED_OSC 2'h2
`define OMSC_CFG_INTERNAL_HIGH_SPEED_OSC_LXT 2'h3

// watchdog clock source codes
`define OMSC_WCK_LXT 2'h0
`define OMSC_WCK_SYS 2'h1
`define OMSC_WCK_INTERNAL_LOW_SPEED_OSC 2'h2

// operating modes
`define OMSC_MODE_NORMAL 2'h0
`define OMSC_MODE_SLOW 2'h1
`define OMSC_MODE_SLEEP 2'h2

`define OMSC_WDT_W 16
`endif

// ===== hw/omsc_tick_div.v
// omsc_tick_div.v: divider giving a one-cycle enable pulse every DIV clocks
// assumes a single clock and a synchronous active-high reset
`timescale 1ns/100ps
module omsc_tick_div #(
    parameter DIV = 8
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire run,
    // output pulse
    output reg tick
);
    reg [15:0] cnt_r;

    always @(posedge clk) begin
        if (rst) begin
            cnt_r <= 16'h0000;
            tick <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else if (cnt_r == DIV[15:0] - 16'h0001) begin
            cnt_r <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule

// ===== hw/omsc_wdt_count.v
// omsc_wdt_count.v: watchdog counter with clear and count enable
// assumes the enable is a one-cycle pulse from the owning block
`timescale 1ns/100ps
`include "omsc_defines.vh"
module omsc_wdt_count #(
    parameter W = `OMSC_WDT_W
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire clr,
    input wire en,
    // state
    output reg [W-1:0] count
);
    always @(posedge clk) begin
        if (rst || clr)
            count <= {W{1'b0}};
        else if (en)
            count <= count + {{(W-1){1'b0}}, 1'b1};
    end
endmodule

// ===== hw/omsc_core.v
// omsc_core.v: operating mode, sleep entry and oscillator run control
// assumes halt, clear-watchdog and wake requests are one-cycle pulses from the
// core on clk; oscillator configuration straps are held stable after reset
`timescale 1ns/100ps
`include "omsc_defines.vh"

// How it works
// - clock speed select picks normal mode on the high oscillator, slow on the crystal.
// - a halt enters sleep whatever the clock speed select holds.
// - sleep stops the high-speed oscillators and freezes execution at the halt.
// - data memory and registers keep their values while asleep.
// - watchdog on its own or crystal clock is cleared at halt and keeps counting.
// - watchdog on the system clock stops during sleep.
// - the port outputs stay frozen at their halt value while asleep.
// - a halt sets the power-down flag and clears the time-out flag.
// - an enabled internal low-speed oscillator keeps running in sleep.
// - a configured low-frequency crystal keeps running in sleep.
// - a crystal low-power bit in system_control_zero drives the crystal low-power input.
// - clock speed select acts only in the high-speed RC plus crystal configuration.
// - power-up and the clear-watchdog instruction clear the power-down flag.
module omsc_core #(
    parameter WDT_SYS_DIV = 4,
    parameter WDT_LOW_DIV = 8,
    parameter PORT_W = 10,
    parameter WDT_W = `OMSC_WDT_W
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // register port
    input wire [`OMSC_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // configuration straps (pins)
    input wire [1:0] osc_cfg_pin,
    input wire [1:0] wdt_clk_src_pin,
    input wire internal_low_speed_osc_en_pin,
    // core events
    input wire halt_exec,
    input wire clr_wdt_exec,
    input wire wake_req,
    input wire wdt_timeout,
    // port data from the core
    input wire [PORT_W-1:0] port_out_core,
    // oscillator controls
    output reg high_freq_crystal_osc_en,
    output reg external_resistor_cap_osc_en,
    output reg internal_high_speed_osc_en,
    output reg low_freq_crystal_osc_en,
    output reg internal_low_speed_osc_en,
    output reg crystal_low_power_bit,
    // system state
    output reg sys_clk_low_sel,
    output reg cpu_hold,
    output reg regs_hold,
    output reg [1:0] op_mode,
    output reg [PORT_W-1:0] port_out,
    output reg [WDT_W-1:0] wdt_count_out,
    output reg power_down_flag,
    output reg watchdog_timeout_flag,
    output reg irq
);
    // strap synchronisers
    reg [4:0] cfg_s1_r;
    reg [4:0] cfg_s2_r;
    reg [4:0] cfg_r;
    reg cfg_ld_r;
    // control registers
    reg clock_speed_select_r;
    reg crystal_low_power_bit_r;
    reg sleep_r;
    reg [`OMSC_EV_W-1:0] ev_stat_r;
    reg [`OMSC_EV_W-1:0] ev_mask_r;
    reg [`OMSC_EV_W-1:0] ev_set;
    reg [1:0] mode_nxt;
    reg [7:0] rdata_nxt;
    wire [1:0] osc_cfg;
    wire [1:0] wck_src;
    wire internal_low_speed_osc_cfg;
    wire speed_valid;
    wire slow_sel;
    wire sys_tick;
    wire low_tick;
    wire wdt_tick;
    wire [WDT_W-1:0] wdt_count;

    function [7:0] omsc_wr_bit;
        input [7:0] cur;
        input [7:0] data;
        input [7:0] mask;
        begin
            omsc_wr_bit = (cur & ~mask) | (data & mask);
        end
    endfunction

    assign osc_cfg = cfg_r[1:0];
    assign wck_src = cfg_r[3:2];
    assign internal_low_speed_osc_cfg = cfg_r[4];

    // straps pass two flops, then are caught once after reset release
    always @(posedge clk) begin
        cfg_s1_r <= {internal_low_speed_osc_en_pin, wdt_clk_src_pin, osc_cfg_pin};
        cfg_s2_r <= cfg_s1_r;
        if (rst) begin
            cfg_ld_r <= 1'b0;
            cfg_r <= 5'h00;
        end else if (!cfg_ld_r) begin
            cfg_ld_r <= 1'b1;
            cfg_r <= cfg_s2_r;
        end
    end

    assign speed_valid = (osc_cfg == `OMSC_CFG_INTERNAL_HIGH_SPEED_OSC_LXT);
    assign slow_sel = speed_valid & clock_speed_select_r;

    // sleep state: entered on halt regardless of speed select, left on wake
    always @(posedge clk) begin
        if (rst)
            sleep_r <= 1'b0;
        else if (!sleep_r && halt_exec)
            sleep_r <= 1'b1;
        else if (sleep_r && wake_req)
            sleep_r <= 1'b0;
    end

    // watchdog ticks: system-derived stops in sleep, low-speed sources run on
    omsc_tick_div #(.DIV(WDT_SYS_DIV)) u_sys_div (
        .clk(clk),
        .rst(rst),
        .run(!sleep_r),
        .tick(sys_tick)
    );

    omsc_tick_div #(.DIV(WDT_LOW_DIV)) u_low_div (
        .clk(clk),
        .rst(rst),
        .run(1'b1),
        .tick(low_tick)
    );

    assign wdt_tick = (wck_src == `OMSC_WCK_SYS) ? sys_tick : low_tick;

    omsc_wdt_count #(.W(WDT_W)) u_wdt (
        .clk(clk),
        .rst(rst),
        .clr((halt_exec && !sleep_r) || clr_wdt_exec),
        .en(wdt_tick),
        .count(wdt_count)
    );

    // flags: halt sets power-down and clears time-out; time-out set wins
    always @(posedge clk) begin
        if (rst) begin
            power_down_flag <= 1'b0;
            watchdog_timeout_flag <= 1'b0;
        end else begin
            if (halt_exec && !sleep_r)
                power_down_flag <= 1'b1;
            else if (clr_wdt_exec)
                power_down_flag <= 1'b0;
            if (wdt_timeout)
                watchdog_timeout_flag <= 1'b1;
            else if (halt_exec && !sleep_r)
                watchdog_timeout_flag <= 1'b0;
        end
    end

    always @* begin
        if (sleep_r)
            mode_nxt = `OMSC_MODE_SLEEP;
        else if (slow_sel)
            mode_nxt = `OMSC_MODE_SLOW;
        else
            mode_nxt = `OMSC_MODE_NORMAL;
    end

    // oscillator enables and system state outputs
    always @(posedge clk) begin
        if (rst) begin
            op_mode <= `OMSC_MODE_NORMAL;
            high_freq_crystal_osc_en <= 1'b0;
            external_resistor_cap_osc_en <= 1'b0;
            internal_high_speed_osc_en <= 1'b0;
            low_freq_crystal_osc_en <= 1'b0;
            internal_low_speed_osc_en <= 1'b0;
            crystal_low_power_bit <= 1'b0;
            sys_clk_low_sel <= 1'b0;
            cpu_hold <= 1'b0;
            regs_hold <= 1'b0;
            port_out <= {PORT_W{1'b0}};
            wdt_count_out <= {WDT_W{1'b0}};
        end else begin
            op_mode <= mode_nxt;
            sys_clk_low_sel <= slow_sel;
            high_freq_crystal_osc_en <= (osc_cfg == `OMSC_CFG_HXT) && !sleep_r;
            external_resistor_cap_osc_en <= (osc_cfg == `OMSC_CFG_ERC) && !sleep_r;
            internal_high_speed_osc_en <= ((osc_cfg == `OMSC_CFG_INTERNAL_HIGH_SPEED_OSC) || speed_valid)
                && !sleep_r && !slow_sel;
            low_freq_crystal_osc_en <= speed_valid;
            internal_low_speed_osc_en <= internal_low_speed_osc_cfg;
            crystal_low_power_bit <= crystal_low_power_bit_r;
            cpu_hold <= sleep_r;
            regs_hold <= sleep_r;
            if (!sleep_r)
                port_out <= port_out_core;
            wdt_count_out <= wdt_count;
        end
    end

    // events: sleep entry, wake, mode change
    always @* begin
        ev_set = {`OMSC_EV_W{1'b0}};
        ev_set[`OMSC_EV_SLEEP_BIT] = halt_exec && !sleep_r;
        ev_set[`OMSC_EV_WAKE_BIT] = wake_req && sleep_r;
        ev_set[`OMSC_EV_MODE_BIT] = (mode_nxt != op_mode) && !sleep_r;
    end

    // register writes; system_control_zero is frozen while asleep, interrupt mask and status still take writes
    always @(posedge clk) begin
        if (rst) begin
            clock_speed_select_r <= 1'b0;
            crystal_low_power_bit_r <= 1'b0;
            ev_stat_r <= {`OMSC_EV_W{1'b0}};
            ev_mask_r <= {`OMSC_EV_W{1'b0}};
        end else begin
            if (reg_wr && !sleep_r && reg_addr == `OMSC_SYSTEM_CONTROL_ZERO_ADDR) begin
                clock_speed_select_r <= reg_wdata[`OMSC_SYSTEM_CONTROL_ZERO_SPEED_BIT];
                crystal_low_power_bit_r <= reg_wdata[`OMSC_SYSTEM_CONTROL_ZERO_CRYSTAL_LOW_POWER_BIT_BIT];
            end
            if (reg_wr && reg_addr == `OMSC_IRQ_MASK_ADDR)
                ev_mask_r <= reg_wdata[`OMSC_EV_W-1:0];
            if (reg_wr && reg_addr == `OMSC_IRQ_STAT_ADDR)
                ev_stat_r <= (ev_stat_r & ~reg_wdata[`OMSC_EV_W-1:0]) | ev_set;
            else
                ev_stat_r <= ev_stat_r | ev_set;
        end
    end

    always @(posedge clk) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(ev_stat_r & ev_mask_r);
    end

    // read mux, data one cycle after the strobe, zero otherwise
    always @* begin
        rdata_nxt = 8'h00;
        case (reg_addr)
            `OMSC_SYSTEM_CONTROL_ZERO_ADDR: begin
                rdata_nxt = omsc_wr_bit(8'h00,
                    {6'h00, crystal_low_power_bit_r, clock_speed_select_r}, 8'h03);
            end
            `OMSC_STATUS_ADDR: begin
                rdata_nxt = {6'h00, power_down_flag, watchdog_timeout_flag};
            end
            `OMSC_MODE_ADDR: begin
                rdata_nxt = {4'h0, osc_cfg, op_mode};
            end
            `OMSC_IRQ_STAT_ADDR: begin
                rdata_nxt = {5'h00, ev_stat_r};
            end
            `OMSC_IRQ_MASK_ADDR: begin
                rdata_nxt = {5'h00, ev_mask_r};
            end
            `OMSC_WDT_ADDR: begin
                rdata_nxt = wdt_count[7:0];
            end
            default: begin
                rdata_nxt = 8'h00;
            end
        endcase
    end

    always @(posedge clk) begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end
endmodule

// ===== verif/omsc_core_properties.sv
// omsc_core_properties.sv: port checks for omsc_core
// assumes straps stable after reset and one-cycle event pulses
`timescale 1ns/100ps
module omsc_chk #(parameter PORT_W = 10, parameter WDT_W = 16) (
    // clock and reset
    input wire clk,
    input wire rst,
    // straps and events
    input wire [1:0] osc_cfg_pin,
    input wire [1:0] wdt_clk_src_pin,
    input wire internal_low_speed_osc_en_pin,
    input wire halt_exec,
    input wire clr_wdt_exec,
    input wire wake_req,
    input wire wdt_timeout,
    // state
    input wire high_freq_crystal_osc_en,
    input wire external_resistor_cap_osc_en,
    input wire internal_high_speed_osc_en,
    input wire low_freq_crystal_osc_en,
    input wire internal_low_speed_osc_en,
    input wire sys_clk_low_sel,
    input wire cpu_hold,
    input wire regs_hold,
    input wire [1:0] op_mode,
    input wire [PORT_W-1:0] port_out,
    input wire [WDT_W-1:0] wdt_count_out,
    input wire power_down_flag,
    input wire watchdog_timeout_flag
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence halt_s;
        halt_exec && !cpu_hold && op_mode != 2'h2 && !$past(halt_exec);
    endsequence
    pdf_on_halt_a: assert property (halt_s ##0 !wdt_timeout |=>
        power_down_flag && !watchdog_timeout_flag) else $error("halt flags wrong");
    sleep_entry_a: assert property (halt_s ##1 !wake_req |=>
        op_mode == 2'h2 && cpu_hold && regs_hold) else $error("no sleep after halt");
    high_osc_stop_a: assert property (op_mode == 2'h2 |-> !(high_freq_crystal_osc_en ||
        external_resistor_cap_osc_en || internal_high_speed_osc_en)) else $error("high osc on");
    low_osc_run_a: assert property (op_mode == 2'h2 |->
        low_freq_crystal_osc_en == (osc_cfg_pin == 2'h3) &&
        internal_low_speed_osc_en == internal_low_speed_osc_en_pin) else $error("low osc wrong in sleep");
    port_hold_a: assert property (cpu_hold && $past(cpu_hold) |-> $stable(port_out))
        else $error("port moved in sleep");
    wdt_stop_a: assert property (cpu_hold && $past(cpu_hold, 2) && wdt_clk_src_pin == 2'h1
        |-> $stable(wdt_count_out)) else $error("watchdog ran in sleep");
    wdt_clear_a: assert property (halt_s ##0 wdt_clk_src_pin != 2'h1 |->
        ##2 wdt_count_out == 0) else $error("watchdog not cleared");
    slow_sel_a: assert property (op_mode == 2'h1 |-> osc_cfg_pin == 2'h3 &&
        sys_clk_low_sel && !internal_high_speed_osc_en) else $error("slow mode wrong");
    pdf_clear_a: assert property (clr_wdt_exec && !halt_exec |=> !power_down_flag)
        else $error("power-down flag kept");
    cover property (halt_s);
    cover property (op_mode == 2'h1);
    cover property (wake_req && cpu_hold);
endmodule
bind omsc_core omsc_chk #(.PORT_W(PORT_W), .WDT_W(WDT_W)) u_chk (.clk, .rst,
    .osc_cfg_pin, .wdt_clk_src_pin, .internal_low_speed_osc_en_pin, .halt_exec, .clr_wdt_exec, .wake_req,
    .wdt_timeout, .high_freq_crystal_osc_en, .external_resistor_cap_osc_en,
    .internal_high_speed_osc_en, .low_freq_crystal_osc_en, .internal_low_speed_osc_en,
    .sys_clk_low_sel, .cpu_hold, .regs_hold, .op_mode, .port_out, .wdt_count_out,
    .power_down_flag, .watchdog_timeout_flag);

// ===== verif/operating_mode_sleep_control_tb_top.sv
// operating_mode_sleep_control_tb_top.sv: self-checking bench for omsc_core
// assumes one clock; straps change only while reset is held
`timescale 1ns/100ps
module operating_mode_sleep_control_tb_top;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, internal_low_speed_osc_en_pin = 1'b1;
    logic halt_exec = 1'b0, clr_wdt_exec = 1'b0, wake_req = 1'b0, wdt_timeout = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic [1:0] osc_cfg_pin = 2'h3, wdt_clk_src_pin = 2'h2, op_mode;
    logic [9:0] port_out_core = 10'h000, port_out;
    logic [15:0] wdt_count_out;
    logic high_freq_crystal_osc_en, external_resistor_cap_osc_en, internal_high_speed_osc_en;
    logic low_freq_crystal_osc_en, internal_low_speed_osc_en, crystal_low_power_bit;
    logic sys_clk_low_sel, cpu_hold, regs_hold, power_down_flag, watchdog_timeout_flag, irq;
    int failures = 0, n_tests = 0, cyc = 0, seed = 32'he043;
    omsc_core u_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .osc_cfg_pin, .wdt_clk_src_pin, .internal_low_speed_osc_en_pin, .halt_exec, .clr_wdt_exec, .wake_req,
        .wdt_timeout, .port_out_core, .high_freq_crystal_osc_en, .external_resistor_cap_osc_en,
        .internal_high_speed_osc_en, .low_freq_crystal_osc_en, .internal_low_speed_osc_en,
        .crystal_low_power_bit, .sys_clk_low_sel, .cpu_hold, .regs_hold, .op_mode, .port_out,
        .wdt_count_out, .power_down_flag, .watchdog_timeout_flag, .irq);
    always #2 clk = ~clk;
    always @(posedge clk) begin
        port_out_core <= 10'($random(seed));
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            summarize;
        end
    end
    task summarize;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task restart(input logic [1:0] c, input logic [1:0] s, input logic l);
        @(posedge clk);
        rst <= 1'b1;
        osc_cfg_pin <= c;
        wdt_clk_src_pin <= s;
        internal_low_speed_osc_en_pin <= l;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rdc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, e);
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        logic [9:0] p;
        logic [15:0] w;
        restart(2'h3, 2'h2, 1'b1);
        rdc(4'h2, 8'hFF, 8'h0C);
        rdc(4'h9, 8'hFF, 8'h00);
        wr(4'h4, 8'h07);
        wr(4'h0, 8'h03);
        wt(3);
        chk(op_mode, 2'h1);
        chk(internal_high_speed_osc_en, 1'b0);
        chk(crystal_low_power_bit, 1'b1);
        wr(4'h3, 8'h07);
        @(posedge clk) wdt_timeout <= 1'b1;
        @(posedge clk) wdt_timeout <= 1'b0;
        @(posedge clk) halt_exec <= 1'b1;
        @(posedge clk) halt_exec <= 1'b0;
        #1 chk(power_down_flag, 1'b1);
        chk(watchdog_timeout_flag, 1'b0);
        wt(1);
        chk(op_mode, 2'h2);
        chk(cpu_hold, 1'b1);
        chk(internal_low_speed_osc_en, 1'b1);
        chk(low_freq_crystal_osc_en, 1'b1);
        p = port_out;
        rdc(4'h1, 8'hFF, 8'h02);
        wr(4'h0, 8'h00);
        rdc(4'h0, 8'hFF, 8'h03);
        rdc(4'h3, 8'h01, 8'h01);
        chk(irq, 1'b1);
        wr(4'h4, 8'h00);
        wt(2);
        chk(irq, 1'b0);
        wr(4'h4, 8'h07);
        wr(4'h3, 8'h07);
        wt(2);
        chk(irq, 1'b0);
        wt(30);
        chk(port_out, p);
        chk(wdt_count_out != 16'h0000, 1'b1);
        @(posedge clk) wake_req <= 1'b1;
        @(posedge clk) wake_req <= 1'b0;
        wt(2);
        chk(cpu_hold, 1'b0);
        chk(op_mode, 2'h1);
        @(posedge clk) clr_wdt_exec <= 1'b1;
        @(posedge clk) clr_wdt_exec <= 1'b0;
        #1 chk(power_down_flag, 1'b0);
        restart(2'h2, 2'h1, 1'b0);
        wr(4'h0, 8'h01);
        wt(3);
        chk(op_mode, 2'h0);
        chk(internal_high_speed_osc_en, 1'b1);
        @(posedge clk) halt_exec <= 1'b1;
        @(posedge clk) halt_exec <= 1'b0;
        wt(3);
        w = wdt_count_out;
        wt(20);
        chk(wdt_count_out, w);
        chk(low_freq_crystal_osc_en, 1'b0);
        chk(internal_low_speed_osc_en, 1'b0);
        restart(2'h1, 2'h2, 1'b0);
        chk(external_resistor_cap_osc_en, 1'b1);
        chk(high_freq_crystal_osc_en, 1'b0);
        restart(2'h0, 2'h0, 1'b1);
        chk(high_freq_crystal_osc_en, 1'b1);
        chk(external_resistor_cap_osc_en, 1'b0);
        @(posedge clk) halt_exec <= 1'b1;
        @(posedge clk) halt_exec <= 1'b0;
        wt(1);
        chk(high_freq_crystal_osc_en, 1'b0);
        chk(regs_hold, 1'b1);
        chk(low_freq_crystal_osc_en, 1'b0);
        chk(internal_low_speed_osc_en, 1'b1);
        summarize;
    end
endmodule
